/* File: rbcs_defines.vh */
/*
 * Constants for the register bank context-switch block: bank slot layout,
 * status word fields, reset values, interrupt control and transfer channel fields and register port offsets.
 * Assumes inclusion by bare name from the design files of this block.
 */
`ifndef RBCS_DEFINES_VH
`define RBCS_DEFINES_VH

// Register bank geometry: eight banks of sixteen 16-bit words.
`define RBCS_BANKS 8
`define RBCS_SLOTS 16
`define RBCS_SLOT_SP 4'h4
`define RBCS_SLOT_PS 4'h9
`define RBCS_SLOT_SS 4'ha
`define RBCS_SLOT_PCSAVE 4'hc
`define RBCS_SLOT_PSWSAVE 4'hd
`define RBCS_SLOT_VECPC 4'he

// Status word flag positions.
`define RBCS_PSW_BRK 8
`define RBCS_PSW_IE 9

// Reset values.
`define RBCS_PSW_RST 16'hf002
`define RBCS_PC_RST 16'h0000
`define RBCS_BANK_RST 3'h7
`define RBCS_PRIO_RST 3'h7

// Interrupt control register fields.
`define RBCS_ICR_PRIO_LSB 0
`define RBCS_ICR_BANK_SWITCH_SELECT 4
`define RBCS_ICR_MS 5
`define RBCS_ICR_MASK 6
`define RBCS_ICR_REQ 7

// Transfer channel fields.
`define RBCS_MSC_RST 8'h00
`define RBCS_MODE_SEARCH 7
`define RBCS_MODE_WORD 5
`define RBCS_MODE_DIR 4

// Register port offsets.
`define RBCS_A_ICR 8'h00
`define RBCS_A_MCR 8'h01
`define RBCS_A_MSC 8'h02
`define RBCS_A_SCHR 8'h03
`define RBCS_A_PSW 8'h04
`define RBCS_A_PC 8'h05
`define RBCS_A_BANK 8'h06
`define RBCS_A_STAT 8'h07
`define RBCS_A_BANKRAM 8'h80

`endif

/* File: rbcs_bank_ram.v */
/*
 * Register bank store: eight banks of sixteen words in flip-flops.
 * Assumes one write port and two combinational read ports on one clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "rbcs_defines.vh"

module rbcs_bank_ram (
   input wire clk,
   input wire rst,
   input wire we,
   input wire [6:0] waddr,
   input wire [15:0] wdata,
   input wire [6:0] raddr_a,
   output wire [15:0] rdata_a,
   input wire [6:0] raddr_b,
   output wire [15:0] rdata_b
);
   reg [15:0] mem_reg [0:127];
   genvar gi;

   // Each word is a plain register; reset clears it so reads are defined.
   generate
      for (gi = 0; gi < 128; gi = gi + 1) begin : g_word
         always @(posedge clk or posedge rst) begin
            if (rst) begin
               mem_reg[gi] <= 16'h0000;
            end else if (we && waddr == gi) begin
               mem_reg[gi] <= wdata;
            end
         end
      end
   endgenerate

   assign rdata_a = mem_reg[raddr_a];
   assign rdata_b = mem_reg[raddr_b];
endmodule
`default_nettype wire

/* File: rbcs_context_switch.v */
/*
 * Context-switch unit: register bank swaps on interrupt, bank call, task
 * switch and bank return, plus the single-source transfer service path.
 * Assumes the core raises one-cycle instruction strobes and services the
 * PC_LOAD output; software uses the plain register port described below.
 */
// Overview of operation
// [RULE1] Bank-switch select set makes an acknowledged request swap banks, not stack.
// [RULE2] Interrupt swap targets the bank equal to the group priority level.
// [RULE3] Save status, switch bank, clear enable/break, store PC/status, load vector.
// [RULE4] Bank return reloads PC and status from current bank save slots.
// [RULE5] Stack return leaves the current register bank unchanged.
// [RULE6] Software issues end-of-service before bank return after interrupt swap.
// [RULE7] Software sets segment and vector slots before any swap.
// [RULE8] Software keeps program segment unchanged inside bank-swap service routines.
// [RULE9] Stack copy loads new bank stack segment and pointer from prior bank.
// [RULE10] Bank call selects operand low bits, saves PC/status, jumps to vector.
// [RULE11] Bank-call swap is undone by bank return alone.
// [RULE12] Task switch saves to current bank, selects new, loads its saves.
// [RULE13] Software initialises destination bank slots before a task switch.
// [RULE14] One bank-switch source per equal-priority group, all same bank.
// [RULE15] Transfer service moves one byte or word per request, no routine.
// [RULE16] Unmasked transfer source runs regardless of interrupt enable, honouring priority.
// [RULE17] Count exhausted or match clears select bit and raises held completion.
// [RULE18] Eight banks in internal storage, each with save and vector slots.
// [RULE19] Priority levels 0 to 7, zero highest, reset to 7.
// [RULE20] Swap completes unbroken; next fetch is vector with new bank.
`timescale 1ns/1ps
`default_nettype none
`include "rbcs_defines.vh"

module rbcs_context_switch (
   input wire CLK_SYS,
   input wire RST,
   input wire [7:0] ADDR,
   input wire [15:0] WDATA,
   input wire WR,
   input wire RD,
   output reg [15:0] RDATA,
   input wire IRQ_PIN,
   input wire [2:0] CUR_LEVEL,
   input wire INSTR_BANK_CALL,
   input wire INSTR_TASK_SWITCH,
   input wire INSTR_BANK_RETURN,
   input wire INSTR_STACK_RETURN,
   input wire INSTR_STACK_COPY,
   input wire [15:0] OPERAND,
   input wire [15:0] XFER_DIN,
   output reg [15:0] PC_OUT,
   output reg [15:0] PSW_OUT,
   output reg [2:0] BANK_OUT,
   output reg PC_LOAD,
   output reg BUSY,
   output reg XFER_STB,
   output reg XFER_DIR,
   output reg XFER_WORD,
   output reg COMPLETE_IRQ
);
   localparam ST_IDLE = 5'b00001;
   localparam ST_SAVE = 5'b00010;
   localparam ST_STPC = 5'b00100;
   localparam ST_STPSW = 5'b01000;
   localparam ST_LOAD = 5'b10000;

   localparam K_IRQ = 2'd0;
   localparam K_CALL = 2'd1;
   localparam K_TASK = 2'd2;
   localparam K_RET = 2'd3;

   // Slot address in the bank store.
   function [6:0] slot_addr;
      input [2:0] bank;
      input [3:0] slot;
      begin
         slot_addr = {bank, slot};
      end
   endfunction

   reg [4:0] state_reg, state_next;
   reg [1:0] kind_reg;
   reg [15:0] tmp_psw_reg;
   reg [2:0] bank_reg, prev_bank_reg;
   reg [15:0] pc_reg, psw_reg;
   reg [7:0] icr_reg;
   reg [7:0] mcr_reg;
   reg [7:0] msc_reg;
   reg [7:0] schr_reg;
   reg [2:0] irq_sync_reg;
   reg irq_seen_reg;
   reg ram_we;
   reg [6:0] ram_waddr;
   reg [15:0] ram_wdata;
   reg [6:0] ram_ra;
   reg [6:0] ram_rb;
   wire [15:0] ram_da, ram_db;
   wire irq_rise;
   wire [2:0] prio;
   wire svc_ok;
   wire xfer_go;
   wire bank_go;
   wire xfer_done;

   // [RULE18] Eight banks with slots
   rbcs_bank_ram u_ram (
      .clk(CLK_SYS),
      .rst(RST),
      .we(ram_we),
      .waddr(ram_waddr),
      .wdata(ram_wdata),
      .raddr_a(ram_ra),
      .rdata_a(ram_da),
      .raddr_b(ram_rb),
      .rdata_b(ram_db)
   );

   // Request pin passes three flops; an edge counts when stages two and three agree.
   always @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         irq_sync_reg <= 3'h0;
         irq_seen_reg <= 1'b0;
      end else begin
         irq_sync_reg <= {irq_sync_reg[1:0], IRQ_PIN};
         if (irq_sync_reg[2] == irq_sync_reg[1]) begin
            irq_seen_reg <= irq_sync_reg[2];
         end
      end
   end
   assign irq_rise = (irq_sync_reg[2] == irq_sync_reg[1]) && irq_sync_reg[2] && !irq_seen_reg;

   assign prio = icr_reg[`RBCS_ICR_PRIO_LSB+2:`RBCS_ICR_PRIO_LSB];
   // [RULE19] Priority compare, zero highest
   assign svc_ok = icr_reg[`RBCS_ICR_REQ] && !icr_reg[`RBCS_ICR_MASK] && (prio < CUR_LEVEL);
   // [RULE16] Transfer ignores enable flag
   assign xfer_go = svc_ok && icr_reg[`RBCS_ICR_MS] && state_reg == ST_IDLE;
   // [RULE1] Bank-switch response selected
   assign bank_go = svc_ok && !icr_reg[`RBCS_ICR_MS] && icr_reg[`RBCS_ICR_BANK_SWITCH_SELECT]
                    && psw_reg[`RBCS_PSW_IE] && state_reg == ST_IDLE;
   // [RULE17] End by count or match
   assign xfer_done = (msc_reg == 8'h01) ||
                      (mcr_reg[`RBCS_MODE_SEARCH] && XFER_DIN[7:0] == schr_reg);

   // Bank store access: swap states own the write port; in idle, stack copy or a software write uses it; software reads on port b.
   always @* begin
      ram_we = 1'b0;
      ram_waddr = 7'h00;
      ram_wdata = 16'h0000;
      ram_ra = slot_addr(bank_reg, `RBCS_SLOT_VECPC);
      ram_rb = ADDR[6:0];
      case (state_reg)
         ST_SAVE: begin
            if (kind_reg == K_TASK) begin
               ram_we = 1'b1;
               ram_waddr = slot_addr(bank_reg, `RBCS_SLOT_PCSAVE);
               ram_wdata = pc_reg;
            end
         end
         ST_STPC: begin
            if (kind_reg == K_TASK) begin
               ram_we = 1'b1;
               ram_waddr = slot_addr(prev_bank_reg, `RBCS_SLOT_PSWSAVE);
               ram_wdata = tmp_psw_reg;
            end else begin
               ram_we = 1'b1;
               ram_waddr = slot_addr(bank_reg, `RBCS_SLOT_PCSAVE);
               ram_wdata = pc_reg;
            end
         end
         ST_STPSW: begin
            ram_we = 1'b1;
            ram_waddr = slot_addr(bank_reg, `RBCS_SLOT_PSWSAVE);
            ram_wdata = tmp_psw_reg;
         end
         ST_LOAD: begin
            if (kind_reg == K_IRQ || kind_reg == K_CALL) begin
               ram_ra = slot_addr(bank_reg, `RBCS_SLOT_VECPC);
            end else begin
               ram_ra = slot_addr(bank_reg, `RBCS_SLOT_PCSAVE);
               ram_rb = slot_addr(bank_reg, `RBCS_SLOT_PSWSAVE);
            end
         end
         default: begin
            if (INSTR_STACK_COPY) begin
               // [RULE9] Prior stack into new bank
               ram_we = 1'b1;
               ram_waddr = slot_addr(bank_reg, OPERAND[0] ? `RBCS_SLOT_SS : `RBCS_SLOT_SP);
               ram_ra = slot_addr(prev_bank_reg, OPERAND[0] ? `RBCS_SLOT_SS : `RBCS_SLOT_SP);
               ram_wdata = ram_da;
            end else if (WR && ADDR[7]) begin
               ram_we = 1'b1;
               ram_waddr = ADDR[6:0];
               ram_wdata = WDATA;
            end
         end
      endcase
   end

   // Sequence steps; each swap runs to its end without a break.
   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (bank_go || INSTR_BANK_CALL || INSTR_TASK_SWITCH) begin
               state_next = ST_SAVE;
            end else if (INSTR_BANK_RETURN) begin
               state_next = ST_LOAD;
            end
         end
         ST_SAVE: state_next = ST_STPC;
         ST_STPC: state_next = (kind_reg == K_TASK) ? ST_LOAD : ST_STPSW;
         ST_STPSW: state_next = ST_LOAD;
         ST_LOAD: state_next = ST_IDLE;
         default: state_next = ST_IDLE;
      endcase
   end

   // Main sequencer, control registers and transfer service.
   always @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         state_reg <= ST_IDLE;
         kind_reg <= K_IRQ;
         tmp_psw_reg <= `RBCS_PSW_RST;
         bank_reg <= `RBCS_BANK_RST;
         prev_bank_reg <= `RBCS_BANK_RST;
         pc_reg <= `RBCS_PC_RST;
         psw_reg <= `RBCS_PSW_RST;
         icr_reg <= {5'h0c, `RBCS_PRIO_RST};
         mcr_reg <= 8'h00;
         msc_reg <= `RBCS_MSC_RST;
         schr_reg <= 8'h00;
         PC_LOAD <= 1'b0;
         XFER_STB <= 1'b0;
         COMPLETE_IRQ <= 1'b0;
      end else begin
         state_reg <= state_next;
         PC_LOAD <= 1'b0;
         XFER_STB <= 1'b0;
         if (WR) begin
            case (ADDR)
               `RBCS_A_ICR: icr_reg <= WDATA[7:0];
               `RBCS_A_MCR: mcr_reg <= WDATA[7:0];
               `RBCS_A_MSC: msc_reg <= WDATA[7:0];
               `RBCS_A_SCHR: schr_reg <= WDATA[7:0];
               `RBCS_A_PSW: psw_reg <= WDATA;
               `RBCS_A_PC: pc_reg <= WDATA;
               default: ;
            endcase
         end
         // A request edge sets the pending flag and wins over a software clear.
         if (irq_rise) begin
            icr_reg[`RBCS_ICR_REQ] <= 1'b1;
         end
         // [RULE15] One unit per request
         if (xfer_go) begin
            XFER_STB <= 1'b1;
            msc_reg <= msc_reg - 8'h01;
            if (xfer_done) begin
               // [RULE17] Select cleared, request kept
               icr_reg[`RBCS_ICR_MS] <= 1'b0;
               COMPLETE_IRQ <= 1'b1;
            end else begin
               icr_reg[`RBCS_ICR_REQ] <= irq_rise;
            end
         end
         // A new completion in the same cycle wins over the release.
         if (COMPLETE_IRQ && psw_reg[`RBCS_PSW_IE] && !icr_reg[`RBCS_ICR_MS]
             && !(xfer_go && xfer_done)) begin
            COMPLETE_IRQ <= 1'b0;
         end
         case (state_reg)
            ST_IDLE: begin
               tmp_psw_reg <= psw_reg;
               // [RULE5] Stack return keeps bank
               if (INSTR_STACK_RETURN) begin
                  bank_reg <= bank_reg;
               end
               // The prior bank is kept only when a swap starts, so a return can find it.
               if (bank_go) begin
                  // [RULE2] Bank equals priority
                  kind_reg <= K_IRQ;
                  prev_bank_reg <= bank_reg;
                  bank_reg <= prio;
                  icr_reg[`RBCS_ICR_REQ] <= irq_rise;
               end else if (INSTR_BANK_CALL) begin
                  // [RULE10] Operand low bits
                  kind_reg <= K_CALL;
                  prev_bank_reg <= bank_reg;
                  bank_reg <= OPERAND[2:0];
               end else if (INSTR_TASK_SWITCH) begin
                  kind_reg <= K_TASK;
                  prev_bank_reg <= bank_reg;
               end else if (INSTR_BANK_RETURN) begin
                  // [RULE4] Restore from current bank
                  kind_reg <= K_RET;
               end
            end
            ST_SAVE: begin
               if (kind_reg != K_TASK) begin
                  // [RULE3] Clear enable and break
                  psw_reg[`RBCS_PSW_IE] <= 1'b0;
                  psw_reg[`RBCS_PSW_BRK] <= 1'b0;
               end
            end
            ST_STPC: begin
               if (kind_reg == K_TASK) begin
                  // [RULE12] Select task bank
                  bank_reg <= OPERAND[2:0];
               end
            end
            ST_LOAD: begin
               // [RULE20] Vector with new bank
               PC_LOAD <= 1'b1;
               if (kind_reg == K_IRQ || kind_reg == K_CALL) begin
                  pc_reg <= ram_da;
               end else begin
                  // [RULE11] Return needs no end-of-service
                  pc_reg <= ram_da;
                  psw_reg <= ram_db;
                  // [RULE4] Back to prior bank
                  if (kind_reg == K_RET) begin
                     bank_reg <= prev_bank_reg;
                  end
               end
            end
            default: ;
         endcase
      end
   end

   // Outputs registered from internal state.
   always @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         PC_OUT <= `RBCS_PC_RST;
         PSW_OUT <= `RBCS_PSW_RST;
         BANK_OUT <= `RBCS_BANK_RST;
         BUSY <= 1'b0;
         XFER_DIR <= 1'b0;
         XFER_WORD <= 1'b0;
         RDATA <= 16'h0000;
      end else begin
         PC_OUT <= pc_reg;
         PSW_OUT <= psw_reg;
         BANK_OUT <= bank_reg;
         BUSY <= (state_next != ST_IDLE);
         XFER_DIR <= mcr_reg[`RBCS_MODE_DIR];
         XFER_WORD <= mcr_reg[`RBCS_MODE_WORD];
         RDATA <= 16'h0000;
         if (RD) begin
            if (ADDR[7]) begin
               RDATA <= ram_db;
            end else begin
               case (ADDR)
                  `RBCS_A_ICR: RDATA <= {8'h00, icr_reg};
                  `RBCS_A_MCR: RDATA <= {8'h00, mcr_reg};
                  `RBCS_A_MSC: RDATA <= {8'h00, msc_reg};
                  `RBCS_A_SCHR: RDATA <= {8'h00, schr_reg};
                  `RBCS_A_PSW: RDATA <= psw_reg;
                  `RBCS_A_PC: RDATA <= pc_reg;
                  `RBCS_A_BANK: RDATA <= {10'h000, prev_bank_reg, bank_reg};
                  `RBCS_A_STAT: RDATA <= {11'h000, COMPLETE_IRQ, state_reg != ST_IDLE, 3'h0};
                  default: RDATA <= 16'h0000;
               endcase
            end
         end
      end
   end
endmodule
`default_nettype wire

/* File: rbcs_cs_props.sv */
/*
 * Checker for the context-switch unit: load timing, pulse widths, reads.
 * Assumes it is bound to rbcs_context_switch on one clock and reset.
 */
`timescale 1ns/1ps
`default_nettype none

module rbcs_cs_props (
   input wire logic CLK_SYS,
   input wire logic RST,
   input wire logic RD,
   input wire logic [15:0] RDATA,
   input wire logic BUSY,
   input wire logic PC_LOAD,
   input wire logic XFER_STB,
   input wire logic [2:0] BANK_OUT,
   input wire logic INSTR_BANK_CALL,
   input wire logic INSTR_TASK_SWITCH,
   input wire logic INSTR_BANK_RETURN,
   input wire logic INSTR_STACK_RETURN
);
   // One domain, so clock and reset are given once for every check.
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (RST);

   // Read data stand only in the cycle after a read strobe.
   a_rdata_idle: assert property (!$past(RD) |-> RDATA == 16'h0000)
      else $error("read data not zero outside the read cycle");
   // Swap sequences end in one load at their fixed distance from the request.
   a_call_load: assert property (
      INSTR_BANK_CALL && !BUSY |=> !PC_LOAD [*3] ##[1:2] PC_LOAD)
      else $error("bank call load not at its fixed distance");
   a_task_load: assert property (
      INSTR_TASK_SWITCH && !BUSY |=> !PC_LOAD [*2] ##[1:2] PC_LOAD)
      else $error("task switch load not at its fixed distance");
   a_return_load: assert property (INSTR_BANK_RETURN && !BUSY |-> ##[1:2] PC_LOAD)
      else $error("bank return gave no load");
   a_stackret_bank: assert property (
      INSTR_STACK_RETURN && !BUSY |=> $stable(BANK_OUT) [*3])
      else $error("stack return changed the bank");
   a_load_pulse: assert property (PC_LOAD |=> !PC_LOAD)
      else $error("load strobe longer than one cycle");
   a_xfer_pulse: assert property (XFER_STB |=> !XFER_STB)
      else $error("transfer strobe longer than one cycle");
   a_busy_bound: assert property ($rose(BUSY) |-> ##[1:8] !BUSY)
      else $error("sequence did not finish in time");
endmodule

bind rbcs_context_switch rbcs_cs_props u_rbcs_cs_props (
   .CLK_SYS(CLK_SYS), .RST(RST), .RD(RD), .RDATA(RDATA), .BUSY(BUSY),
   .PC_LOAD(PC_LOAD), .XFER_STB(XFER_STB), .BANK_OUT(BANK_OUT),
   .INSTR_BANK_CALL(INSTR_BANK_CALL), .INSTR_TASK_SWITCH(INSTR_TASK_SWITCH),
   .INSTR_BANK_RETURN(INSTR_BANK_RETURN), .INSTR_STACK_RETURN(INSTR_STACK_RETURN)
);

`default_nettype wire

/* File: tb.sv */
/*
 * Self-checking bench for the context-switch unit: register port, swaps,
 * returns, stack copy and the transfer service.
 * Assumes the design files and the checker are compiled before it.
 */
`timescale 1ns/1ps
`default_nettype none
`include "rbcs_defines.vh"

module tb;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [15:0] wdata = 16'h0000;
   logic wr_s = 1'b0;
   logic rd_s = 1'b0;
   logic irq_pin = 1'b0;
   logic [4:0] ins = 5'h00;
   logic [15:0] operand = 16'h0000;
   logic [15:0] xdin = 16'h0000;
   wire [15:0] rdata;
   wire [15:0] pc_out;
   wire [15:0] psw_out;
   wire [2:0] bank;
   wire pc_load, busy, xstb, xdir, xword, cirq;
   int err_count = 0;
   int n_compared = 0;

   // Core clock at 40 MHz.
   always #12.5 clk = ~clk;

   // Instruction strobes: 0 call, 1 task, 2 return, 3 stack return, 4 copy.
   rbcs_context_switch u_rbcs_context_switch (
      .CLK_SYS(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s),
      .RDATA(rdata), .IRQ_PIN(irq_pin), .CUR_LEVEL(3'h7), .INSTR_BANK_CALL(ins[0]),
      .INSTR_TASK_SWITCH(ins[1]), .INSTR_BANK_RETURN(ins[2]),
      .INSTR_STACK_RETURN(ins[3]), .INSTR_STACK_COPY(ins[4]), .OPERAND(operand),
      .XFER_DIN(xdin), .PC_OUT(pc_out), .PSW_OUT(psw_out), .BANK_OUT(bank),
      .PC_LOAD(pc_load), .BUSY(busy), .XFER_STB(xstb), .XFER_DIR(xdir),
      .XFER_WORD(xword), .COMPLETE_IRQ(cirq)
   );

   task automatic complete_run();
      $display("Compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic chk(input logic [15:0] exp, input logic [15:0] got);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: expected %h, got %h", $time, exp, got);
      end
   endtask

   function automatic logic [7:0] ba(input logic [2:0] b, input logic [3:0] s);
      return {1'b1, b, s};
   endfunction

   // Strobes last one cycle and are lowered at the following edge.
   task automatic wr(input logic [7:0] a, input logic [15:0] v);
      @(posedge clk);
      wr_s <= 1'b1;
      addr <= a;
      wdata <= v;
      @(posedge clk);
      wr_s <= 1'b0;
   endtask

   // Read data are taken just after the edge that ends the read cycle.
   task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
      @(posedge clk);
      rd_s <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd_s <= 1'b0;
      #1;
      chk(exp, rdata);
   endtask

   // Bounded wait for a load or transfer strobe, then let copies settle.
   task automatic wait_ev(input bit xfer);
      int i;
      for (i = 0; i < 16 && (xfer ? xstb : pc_load) !== 1'b1; i++) begin
         @(posedge clk);
         #1;
      end
      chk(16'h0001, {15'h0000, i < 16});
      repeat (3) @(posedge clk);
      #1;
      chk(16'h0000, {15'h0000, busy});
   endtask

   task automatic run(input int k, input logic [15:0] op, input bit wl);
      @(posedge clk);
      ins[k] <= 1'b1;
      operand <= op;
      @(posedge clk);
      ins <= 5'h00;
      if (wl)
         wait_ev(1'b0);
      else
         repeat (4) @(posedge clk);
   endtask

   // The request is held three cycles, since the pin filter wants two agreeing stages.
   task automatic irq();
      @(posedge clk);
      irq_pin <= 1'b1;
      repeat (3) @(posedge clk);
      irq_pin <= 1'b0;
   endtask

   task automatic outs(input logic [15:0] pc, input logic [2:0] b);
      chk(pc, pc_out);
      chk({13'h0000, b}, {13'h0000, bank});
   endtask

   task automatic t_reset();
      #1;
      outs(`RBCS_PC_RST, `RBCS_BANK_RST);
      chk(`RBCS_PSW_RST, psw_out);
      rdc(`RBCS_A_ICR, 16'h0067);
      rdc(8'h10, 16'h0000);
   endtask

   // Operand high bits are set to show that only the low three count.
   // Segment and vector slots of the target bank are set before the call.
   task automatic t_call_return();
      wr(`RBCS_A_PC, 16'h0100);
      wr(`RBCS_A_PSW, 16'hf302);
      wr(ba(3'h3, `RBCS_SLOT_PS), 16'h0000);
      wr(ba(3'h3, `RBCS_SLOT_VECPC), 16'h3333);
      run(0, 16'hfff3, 1'b1);
      outs(16'h3333, 3'h3);
      rdc(ba(3'h3, `RBCS_SLOT_PCSAVE), 16'h0100);
      rdc(ba(3'h3, `RBCS_SLOT_PSWSAVE), 16'hf302);
      run(2, 16'h0000, 1'b1);
      outs(16'h0100, 3'h7);
      chk(16'hf302, psw_out);
   endtask

   // This is the only bank-switch source of its group.
   // The routine never writes its program segment.
   // The routine is left by task switch, not bank return, so no end-of-service is owed.
   task automatic t_irq_swap();
      wr(ba(3'h7, `RBCS_SLOT_SS), 16'haaaa);
      wr(ba(3'h7, `RBCS_SLOT_SP), 16'h5555);
      wr(ba(3'h2, `RBCS_SLOT_PS), 16'h0000);
      wr(ba(3'h2, `RBCS_SLOT_VECPC), 16'h2222);
      wr(`RBCS_A_ICR, 16'h0012);
      irq();
      wait_ev(1'b0);
      outs(16'h2222, 3'h2);
      chk(16'hf002, psw_out);
      rdc(ba(3'h2, `RBCS_SLOT_PCSAVE), 16'h0100);
      rdc(ba(3'h2, `RBCS_SLOT_PSWSAVE), 16'hf302);
      rdc(`RBCS_A_ICR, 16'h0012);
   endtask

   task automatic t_stack();
      run(3, 16'h0000, 1'b0);
      chk(16'h0002, {13'h0000, bank});
      run(4, 16'h0001, 1'b0);
      rdc(ba(3'h2, `RBCS_SLOT_SS), 16'haaaa);
      run(4, 16'h0000, 1'b0);
      rdc(ba(3'h2, `RBCS_SLOT_SP), 16'h5555);
   endtask

   // Every slot the destination bank needs is set before the switch.
   task automatic t_task();
      wr(ba(3'h5, `RBCS_SLOT_PS), 16'h0000);
      wr(ba(3'h5, `RBCS_SLOT_SS), 16'h1000);
      wr(ba(3'h5, `RBCS_SLOT_SP), 16'h0200);
      wr(ba(3'h5, `RBCS_SLOT_PCSAVE), 16'h5a5a);
      wr(ba(3'h5, `RBCS_SLOT_PSWSAVE), 16'hf202);
      run(1, 16'h0005, 1'b1);
      outs(16'h5a5a, 3'h5);
      chk(16'hf202, psw_out);
      rdc(ba(3'h2, `RBCS_SLOT_PCSAVE), 16'h2222);
      rdc(ba(3'h2, `RBCS_SLOT_PSWSAVE), 16'hf002);
   endtask

   // Interrupts stay disabled, so the service must still run and then wait.
   task automatic t_xfer();
      wr(`RBCS_A_PSW, 16'hf002);
      wr(`RBCS_A_MCR, 16'h0030);
      wr(`RBCS_A_MSC, 16'h0002);
      wr(`RBCS_A_ICR, 16'h0021);
      irq();
      wait_ev(1'b1);
      chk(16'h0003, {14'h0000, xword, xdir});
      irq();
      wait_ev(1'b1);
      rdc(`RBCS_A_ICR, 16'h0081);
      chk(16'h0001, {15'h0000, cirq});
      rdc(`RBCS_A_STAT, 16'h0010);
   endtask

   // Search mode ends on the first matching datum, long before the count runs out.
   task automatic t_search();
      wr(`RBCS_A_MCR, 16'h0080);
      xdin <= 16'h005a;
      wr(`RBCS_A_SCHR, 16'h005a);
      wr(`RBCS_A_MSC, 16'h0005);
      wr(`RBCS_A_ICR, 16'h0021);
      irq();
      wait_ev(1'b1);
      rdc(`RBCS_A_ICR, 16'h0081);
      rdc(`RBCS_A_MSC, 16'h0004);
   endtask

   // Main sequence after sixteen cycles of reset.
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_call_return();
      t_irq_swap();
      t_stack();
      t_task();
      t_xfer();
      t_search();
      complete_run();
   end

   // Watchdog well beyond the few hundred cycles the tests need.
   initial begin
      #100000;
      err_count++;
      complete_run();
   end
endmodule

`default_nettype wire
